// ==== design/chip_cfg_consts.svh ====
`ifndef CHIP_CFG_CONSTS_SVH
`define CHIP_CFG_CONSTS_SVH

`define MODE_SPECIAL_SINGLE 3'h0
`define MODE_EMU_NARROW 3'h1
`define MODE_SPECIAL_TEST 3'h2
`define MODE_EMU_WIDE 3'h3
`define MODE_NORMAL_SINGLE 3'h4
`define MODE_NORMAL_NARROW 3'h5
`define MODE_PERIPHERAL 3'h6
`define MODE_NORMAL_WIDE 3'h7
`define MODE_RESET_VAL 3'h4
`define VERIFY_CYCLES 8'h10
`define LP_RUN 2'h0
`define LP_STOP 2'h1
`define LP_PSEUDO 2'h2
`define LP_WAIT 2'h3

`endif

// ==== design/chip_cfg_pkg.sv ====
package chip_cfg_pkg;
   typedef logic [2:0] mode_t;
   typedef enum logic [1:0] {
      pwr_run = 2'b00,
      pwr_stop = 2'b01,
      pwr_pseudo = 2'b10,
      pwr_wait = 2'b11
   } pwr_state_e;
endpackage : chip_cfg_pkg

// ==== design/strap_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface strap_if;
   logic [2:0] mode;
   logic flash_map;
   logic osc_type;
   logic captured;
   modport cap (output mode, flash_map, osc_type, captured);
   modport use_side (input mode, flash_map, osc_type, captured);
endinterface : strap_if
`default_nettype wire

// ==== design/strap_capture.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "chip_cfg_consts.svh"
module strap_capture (
   input wire logic clk,
   input wire logic rst,
   // raw board pins
   input wire logic [2:0] mode_pins,
   input wire logic flash_map_strap,
   input wire logic osc_type_strap,
   // captured values
   strap_if.cap straps
);
   import chip_cfg_pkg::*;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic rst_d;

   // two flops before any use of pin levels
   always_ff @(posedge clk) begin
      sync1 <= {mode_pins, flash_map_strap, osc_type_strap};
      sync2 <= sync1;
      rst_d <= rst;
   end

   // ---------------------------------------------
   // latch on reset release
   // ---------------------------------------------
   wire release_edge = rst_d & ~rst;
   always_ff @(posedge clk) begin
      if (rst) begin
         straps.captured <= 1'b0;
      end else if (release_edge) begin
         straps.captured <= 1'b1;
      end
   end
   // sampled at the release edge only; board holds straps steady
   always_ff @(posedge clk) begin
      if (release_edge) begin
         straps.mode <= sync2[4:2];
         straps.flash_map <= sync2[1];
         straps.osc_type <= sync2[0];
      end
   end
endmodule : strap_capture
`default_nettype wire

// ==== design/chip_mode_security_power_ctl.sv ====
// Function
// - mode pins latched at reset release
// - mode readable; limited runtime changes
// - flash map strap latched at release
// - flash visible bit maps internal flash
// - 000 special single, debug active, visible
// - other modes need debug activate command
// - 001 emulation narrow, visible = ~strap
// - 010 special test, flash hidden
// - 011 emulation wide, visible = ~strap
// - 100 normal single, flash visible
// - 101 normal narrow, visible = strap
// - 111 normal wide, visible = strap
// - osc strap 1 colpitts, 0 pierce
// - programmed security survives resets
// - secured single chip refuses debug
// - secured expanded: flash off, no debug
// - erase, special single, verify, reprogram
// - reset before reprogram resecures
// - stop halts clocks, oscillator; reset/ext irq wake
// - pseudo stop keeps osc, tick, watchdog
// - wait halts cpu, peripherals keep running
`timescale 1ns/1ns
`default_nettype none
`include "chip_cfg_consts.svh"
module chip_mode_security_power_ctl (
   input wire logic clk,
   input wire logic rst,
   // board straps
   input wire logic mode_sel_hi,
   input wire logic mode_sel_mid,
   input wire logic mode_sel_lo,
   input wire logic flash_map_strap,
   input wire logic osc_type_strap,
   // non-volatile security and flash state
   input wire logic nv_secured,
   input wire logic flash_erased,
   // debug host
   input wire logic debug_activate_cmd,
   input wire logic debug_op_req,
   // software mode write
   input wire logic mode_wr,
   input wire logic [2:0] mode_wr_data,
   // cpu power requests and wake
   input wire logic stop_instr,
   input wire logic pseudo_stop_en,
   input wire logic idle_halt_instruction,
   input wire logic ext_irq,
   input wire logic any_irq,
   // configuration outputs
   output chip_cfg_pkg::mode_t mode,
   output logic flash_visible,
   output logic flash_in_map,
   output logic osc_colpitts,
   output logic cfg_valid,
   // security and debug
   output logic secured,
   output logic background_debug,
   output logic debug_allowed,
   output logic debug_op_grant,
   output logic debug_op_refused,
   output logic verify_busy,
   output logic verify_done,
   // power control
   output chip_cfg_pkg::pwr_state_e pwr_state,
   output logic osc_run,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic tick_wdog_clk_en,
   output logic cpu_halt
);
   import chip_cfg_pkg::*;

   strap_if straps ();

   strap_capture u_cap (
      .clk(clk),
      .rst(rst),
      .mode_pins({mode_sel_hi, mode_sel_mid, mode_sel_lo}),
      .flash_map_strap(flash_map_strap),
      .osc_type_strap(osc_type_strap),
      .straps(straps)
   );

   // ---------------------------------------------
   // strap decode
   // ---------------------------------------------
   function automatic logic visible_for(input logic [2:0] m, input logic strap);
      logic v;
      v = 1'b1;
      unique case (m)
         `MODE_SPECIAL_SINGLE: v = 1'b1;
         `MODE_EMU_NARROW: v = ~strap;
         `MODE_SPECIAL_TEST: v = 1'b0;
         `MODE_EMU_WIDE: v = ~strap;
         `MODE_NORMAL_SINGLE: v = 1'b1;
         `MODE_NORMAL_NARROW: v = strap;
         `MODE_PERIPHERAL: v = 1'b1;
         `MODE_NORMAL_WIDE: v = strap;
      endcase
      return v;
   endfunction : visible_for

   function automatic logic is_expanded(input logic [2:0] m);
      return (m != `MODE_SPECIAL_SINGLE) && (m != `MODE_NORMAL_SINGLE);
   endfunction : is_expanded

   logic cap_d;
   wire cap_now = straps.captured & ~cap_d;
   wire strap_vis = visible_for(straps.mode, straps.flash_map);
   wire strap_special = (straps.mode == `MODE_SPECIAL_SINGLE);
   // secured expanded start runs from external memory only
   wire strap_sec_exp = nv_secured & is_expanded(straps.mode);

   // limited switching: only special modes may move, never into special single
   // or the reserved peripheral code
   wire mode_is_special = ~mode[2];
   wire mode_wr_ok = mode_wr & cfg_valid & mode_is_special & ~secured
      & (mode_wr_data != `MODE_SPECIAL_SINGLE) & (mode_wr_data != `MODE_PERIPHERAL);

   always_ff @(posedge clk) begin
      if (rst) begin
         cap_d <= 1'b0;
         cfg_valid <= 1'b0;
         mode <= `MODE_RESET_VAL;
         flash_visible <= 1'b0;
         flash_in_map <= 1'b0;
         osc_colpitts <= 1'b0;
      end else begin
         cap_d <= straps.captured;
         if (cap_now) begin
            cfg_valid <= 1'b1;
            mode <= straps.mode;
            flash_visible <= strap_vis;
            flash_in_map <= strap_vis & ~strap_sec_exp;
            osc_colpitts <= straps.osc_type;
         end else if (mode_wr_ok) begin
            mode <= mode_wr_data;
            flash_in_map <= flash_visible & ~(secured & is_expanded(mode_wr_data));
         end
      end
   end

   // ---------------------------------------------
   // security and debug
   // ---------------------------------------------
   // secured comes back from nv bits on every reset until reprogrammed
   logic [7:0] verify_cnt;
   wire verify_start = cap_now & strap_special & nv_secured & flash_erased;
   wire verify_end = verify_busy & (verify_cnt == 8'h01);

   always_ff @(posedge clk) begin
      if (rst) begin
         secured <= 1'b1;
         verify_busy <= 1'b0;
         verify_done <= 1'b0;
         verify_cnt <= 8'h00;
      end else begin
         if (cap_now) begin
            secured <= nv_secured;
         end else if (verify_end) begin
            secured <= 1'b0;
         end
         if (verify_start) begin
            verify_busy <= 1'b1;
            verify_cnt <= `VERIFY_CYCLES;
         end else if (verify_busy) begin
            verify_cnt <= verify_cnt - 8'h01;
            if (verify_end) begin
               verify_busy <= 1'b0;
               verify_done <= 1'b1;
            end
         end
      end
   end

   wire next_debug_allowed = cfg_valid & ~secured;
   always_ff @(posedge clk) begin
      if (rst) begin
         background_debug <= 1'b0;
         debug_allowed <= 1'b0;
         debug_op_grant <= 1'b0;
         debug_op_refused <= 1'b0;
      end else begin
         debug_allowed <= next_debug_allowed;
         if (cap_now & strap_special) begin
            background_debug <= 1'b1;
         end else if (debug_activate_cmd & cfg_valid) begin
            background_debug <= 1'b1;
         end
         debug_op_grant <= debug_op_req & background_debug & debug_allowed;
         debug_op_refused <= debug_op_req & ~(background_debug & debug_allowed);
      end
   end

   // ---------------------------------------------
   // low power
   // ---------------------------------------------
   pwr_state_e state;
   pwr_state_e next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         pwr_run: begin
            if (stop_instr) begin
               next_state = pseudo_stop_en ? pwr_pseudo : pwr_stop;
            end else if (idle_halt_instruction) begin
               next_state = pwr_wait;
            end
         end
         pwr_stop: if (ext_irq) next_state = pwr_run;
         pwr_pseudo: if (ext_irq) next_state = pwr_run;
         pwr_wait: if (any_irq) next_state = pwr_run;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= pwr_run;
         pwr_state <= pwr_run;
         osc_run <= 1'b1;
         core_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         tick_wdog_clk_en <= 1'b1;
         cpu_halt <= 1'b0;
      end else begin
         state <= next_state;
         pwr_state <= next_state;
         osc_run <= next_state != pwr_stop;
         core_clk_en <= next_state == pwr_run;
         periph_clk_en <= (next_state == pwr_run) | (next_state == pwr_wait);
         tick_wdog_clk_en <= next_state != pwr_stop;
         cpu_halt <= next_state != pwr_run;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // erase-verify span as a plain count for the delay below
   localparam int VERIFY_SPAN = int'(`VERIFY_CYCLES);

   a_mode_latch: assert property (cap_now |=> mode == $past(straps.mode))
      else $error("mode not latched from straps");
   a_vis_special: assert property (cap_now && strap_special |=> flash_visible && background_debug)
      else $error("special single chip setup wrong");
   a_vis_test: assert property (cap_now && straps.mode == `MODE_SPECIAL_TEST |=> !flash_visible)
      else $error("special test flash not hidden");
   a_vis_normal: assert property (cap_now && straps.mode == `MODE_NORMAL_WIDE
      |=> flash_visible == $past(straps.flash_map))
      else $error("normal wide visibility wrong");
   a_sec_debug: assert property (secured |-> ##2 !debug_op_grant)
      else $error("debug granted while secured");
   a_sec_flash: assert property (cap_now && strap_sec_exp |=> !flash_in_map)
      else $error("secured expanded flash mapped");
   a_stop_clocks: assert property (pwr_state == pwr_stop |-> !osc_run && !core_clk_en)
      else $error("stop left clocks on");
   a_pseudo_osc: assert property (pwr_state == pwr_pseudo |-> osc_run && tick_wdog_clk_en && !periph_clk_en)
      else $error("pseudo stop clocks wrong");
   a_wait_periph: assert property (pwr_state == pwr_wait |-> cpu_halt && periph_clk_en)
      else $error("wait mode clocks wrong");
   a_osc_type: assert property (cap_now |=> osc_colpitts == $past(straps.osc_type))
      else $error("oscillator select wrong");
   a_vis_single: assert property (cap_now && straps.mode == `MODE_NORMAL_SINGLE |=> flash_visible)
      else $error("normal single chip flash hidden");
   a_vis_emu: assert property (cap_now && straps.mode == `MODE_EMU_NARROW
      |=> flash_visible == !$past(straps.flash_map))
      else $error("emulation narrow visibility wrong");
   a_vis_narrow: assert property (cap_now && straps.mode == `MODE_NORMAL_NARROW
      |=> flash_visible == $past(straps.flash_map))
      else $error("normal narrow visibility wrong");
   a_map_follow: assert property (cfg_valid && !secured |-> flash_in_map == flash_visible)
      else $error("flash map differs from visible bit");
   a_secure_boot: assert property (cap_now |=> secured == $past(nv_secured))
      else $error("security not reloaded at reset");
   // unlock only after the full verify span, never early
   a_verify_len: assert property (verify_start |-> ##VERIFY_SPAN verify_busy
      ##1 (!verify_busy && verify_done && !secured))
      else $error("erase verify length wrong");
   a_mode_hold: assert property (mode_wr && !mode_wr_ok && !cap_now |=> mode == $past(mode))
      else $error("illegal mode write took effect");
   a_debug_gate: assert property (debug_op_req && !(background_debug && debug_allowed)
      |=> debug_op_refused && !debug_op_grant)
      else $error("debug op not refused");
   a_stop_wake: assert property (pwr_state == pwr_stop && ext_irq |=> pwr_state == pwr_run)
      else $error("stop did not wake on interrupt");
   a_run_clocks: assert property (pwr_state == pwr_run
      |-> osc_run && core_clk_en && periph_clk_en && !cpu_halt)
      else $error("run mode clocks wrong");

   c_special: cover property (cap_now && strap_special);
   c_verify: cover property (verify_done);
   c_stop_wake: cover property (pwr_state == pwr_stop ##1 pwr_state == pwr_run);
   c_wait: cover property (pwr_state == pwr_wait);
   c_mode_write: cover property (mode_wr_ok);
endmodule : chip_mode_security_power_ctl
`default_nettype wire

// ==== tb/board_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module board_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // strapping and commands wanted by the bench
   input wire logic [2:0] cfg_mode,
   input wire logic cfg_map,
   input wire logic cfg_osc,
   input wire logic send_act,
   input wire logic send_op,
   // board pins and host serial commands
   output logic mode_sel_hi,
   output logic mode_sel_mid,
   output logic mode_sel_lo,
   output logic flash_map_strap,
   output logic osc_type_strap,
   output logic debug_activate_cmd,
   output logic debug_op_req
);
   initial begin
      {mode_sel_hi, mode_sel_mid, mode_sel_lo, flash_map_strap, osc_type_strap} = 5'h10;
      {debug_activate_cmd, debug_op_req} = 2'h0;
   end
   // ----------------------------------------
   // straps
   // ----------------------------------------
   // pins move only while reset is held, so the capture edge sees settled levels
   always @(posedge clk) begin
      if (rst && cfg_mode != 3'h6) begin
         {mode_sel_hi, mode_sel_mid, mode_sel_lo} <= cfg_mode;
         flash_map_strap <= cfg_map;
         osc_type_strap <= cfg_osc;
      end
   end
   // host commands are single-cycle pulses
   always @(posedge clk) begin
      debug_activate_cmd <= send_act;
      debug_op_req <= send_op;
   end
endmodule : board_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
   import chip_cfg_pkg::*;
   logic clk, mode_sel_hi, mode_sel_mid, mode_sel_lo, flash_map_strap, osc_type_strap;
   logic debug_activate_cmd, debug_op_req, flash_visible, flash_in_map, osc_colpitts, cfg_valid, secured;
   logic background_debug, debug_allowed, debug_op_grant, debug_op_refused, verify_busy, verify_done;
   logic osc_run, core_clk_en, periph_clk_en, tick_wdog_clk_en, cpu_halt;
   logic rst = 1'b1, nv_secured = 1'b0, flash_erased = 1'b0, mode_wr = 1'b0, stop_instr = 1'b0;
   logic pseudo_stop_en = 1'b0, idle_halt_instruction = 1'b0, ext_irq = 1'b0, any_irq = 1'b0;
   logic cfg_map = 1'b0, cfg_osc = 1'b0, send_act = 1'b0, send_op = 1'b0;
   logic [2:0] mode_wr_data = 3'h0, cfg_mode = 3'h4;
   mode_t mode;
   pwr_state_e pwr_state;
   int err_total = 0, compares = 0, cycles = 0;
   chip_mode_security_power_ctl dut (.clk, .rst, .mode_sel_hi, .mode_sel_mid, .mode_sel_lo, .flash_map_strap,
      .osc_type_strap, .nv_secured, .flash_erased, .debug_activate_cmd, .debug_op_req, .mode_wr, .mode_wr_data,
      .stop_instr, .pseudo_stop_en, .idle_halt_instruction, .ext_irq, .any_irq, .mode, .flash_visible,
      .flash_in_map, .osc_colpitts, .cfg_valid, .secured, .background_debug, .debug_allowed, .debug_op_grant,
      .debug_op_refused, .verify_busy, .verify_done, .pwr_state, .osc_run, .core_clk_en, .periph_clk_en,
      .tick_wdog_clk_en, .cpu_halt);
   board_host_model partner (.clk, .rst, .cfg_mode, .cfg_map, .cfg_osc, .send_act, .send_op, .mode_sel_hi,
      .mode_sel_mid, .mode_sel_lo, .flash_map_strap, .osc_type_strap, .debug_activate_cmd, .debug_op_req);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic vis(input logic [2:0] m, input logic s);
      case (m)
         3'h0, 3'h4: vis = 1'b1;
         3'h1, 3'h3: vis = !s;
         3'h2: vis = 1'b0;
         default: vis = s;
      endcase
   endfunction : vis
   task automatic boot(input logic [2:0] m, input logic s, input logic o, input logic sec);
      @(posedge clk);
      cfg_mode <= m;
      cfg_map <= s;
      cfg_osc <= o;
      nv_secured <= sec;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : boot
   // one host request; grant and refusal are pulses, so both are gathered over a short window
   task automatic dbg(input logic act, output logic g, output logic r);
      @(posedge clk) begin
         send_act <= act;
         send_op <= !act;
      end
      @(posedge clk) begin
         send_act <= 1'b0;
         send_op <= 1'b0;
      end
      g = 1'b0;
      r = 1'b0;
      repeat (4) begin
         @(posedge clk);
         #1;
         g = g | debug_op_grant;
         r = r | debug_op_refused;
      end
   endtask : dbg
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_modes;
      logic [2:0] m;
      for (int i = 0; i < 16; i++) begin
         m = i[3:1];
         if (m != 3'h6) begin
            boot(m, i[0], !i[0], 1'b0);
            chk("mode", mode, m);
            chk("cfg_valid", cfg_valid, 1'b1);
            chk("flash_visible", flash_visible, vis(m, i[0]));
            chk("flash_in_map", flash_in_map, vis(m, i[0]));
            chk("osc_colpitts", osc_colpitts, !i[0]);
            chk("debug_active", background_debug, m == 3'h0);
            chk("debug_allowed", debug_allowed, 1'b1);
         end
      end
   endtask : t_modes
   task automatic t_debug;
      logic g, r;
      boot(3'h4, 1'b0, 1'b0, 1'b0);
      dbg(1'b0, g, r);
      chk("op_inactive", {g, r}, 2'b01);
      dbg(1'b1, g, r);
      chk("activated", background_debug, 1'b1);
      dbg(1'b0, g, r);
      chk("op_granted", {g, r}, 2'b10);
      boot(3'h4, 1'b0, 1'b0, 1'b1);
      chk("secured", secured, 1'b1);
      chk("debug_blocked", debug_allowed, 1'b0);
      dbg(1'b1, g, r);
      dbg(1'b0, g, r);
      chk("op_secured", {g, r}, 2'b01);
      chk("map_single", flash_in_map, 1'b1);
      boot(3'h5, 1'b1, 1'b0, 1'b1);
      chk("map_expanded", flash_in_map, 1'b0);
      dbg(1'b1, g, r);
      dbg(1'b0, g, r);
      chk("op_expanded", {g, r}, 2'b01);
   endtask : t_debug
   task automatic t_unsecure;
      @(posedge clk) flash_erased <= 1'b1;
      boot(3'h0, 1'b0, 1'b0, 1'b1);
      chk("verifying", {verify_busy, secured}, 2'b11);
      repeat (20) @(posedge clk);
      #1;
      chk("verified", {verify_busy, verify_done, secured}, 3'b010);
      @(posedge clk) begin
         mode_wr <= 1'b1;
         mode_wr_data <= 3'h6;
      end
      @(posedge clk) mode_wr_data <= 3'h7;
      @(posedge clk) mode_wr_data <= 3'h1;
      @(posedge clk) mode_wr <= 1'b0;
      #1;
      chk("mode_write", mode, 3'h7);
      boot(3'h4, 1'b0, 1'b0, 1'b1);
      chk("resecured", secured, 1'b1);
      @(posedge clk) flash_erased <= 1'b0;
   endtask : t_unsecure
   task automatic t_pwr(input logic ps, input logic wt, input pwr_state_e st, input logic [2:0] en);
      @(posedge clk) begin
         pseudo_stop_en <= ps;
         stop_instr <= !wt;
         idle_halt_instruction <= wt;
      end
      @(posedge clk) begin
         stop_instr <= 1'b0;
         idle_halt_instruction <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
      chk("pwr_state", pwr_state, st);
      chk("clk_enables", {osc_run, periph_clk_en, tick_wdog_clk_en, core_clk_en}, {en, 1'b0});
      chk("cpu_halt", cpu_halt, 1'b1);
      @(posedge clk) begin
         ext_irq <= !wt;
         any_irq <= wt;
      end
      @(posedge clk) begin
         ext_irq <= 1'b0;
         any_irq <= 1'b0;
      end
      #1;
      chk("woken", pwr_state, pwr_run);
      chk("clocks_back", {osc_run, core_clk_en, periph_clk_en, tick_wdog_clk_en}, 4'hf);
      chk("cpu_running", cpu_halt, 1'b0);
   endtask : t_pwr
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      t_modes();
      t_debug();
      t_unsecure();
      t_pwr(1'b0, 1'b0, pwr_stop, 3'b000);
      t_pwr(1'b1, 1'b0, pwr_pseudo, 3'b101);
      t_pwr(1'b0, 1'b1, pwr_wait, 3'b111);
      summarize();
   end
endmodule : tb
`default_nettype wire
